// ---- core/program_flow_sequencer_regs.vh ----
// constants for the program flow sequencer: widths, condition codes,
// loop states and pipeline counts.
// assumes it is included by bare name before any module that uses it.
`ifndef PROGRAM_FLOW_SEQUENCER_REGS_VH
`define PROGRAM_FLOW_SEQUENCER_REGS_VH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define ADDR_W         24
`define CNT_W          32
`define COND_W         4
`define FLAG_W         4

// ------------------------------------------------------------
// flag positions in the flags bus
// ------------------------------------------------------------
`define FLAG_C         0
`define FLAG_V         1
`define FLAG_Z         2
`define FLAG_N         3

// ------------------------------------------------------------
// condition codes
// ------------------------------------------------------------
`define COND_U         4'h0
`define COND_LO        4'h1
`define COND_LS        4'h2
`define COND_HI        4'h3
`define COND_HS        4'h4
`define COND_EQ        4'h5
`define COND_NE        4'h6
`define COND_LT        4'h7
`define COND_LE        4'h8
`define COND_GT        4'h9
`define COND_GE        4'ha
`define COND_NV        4'hb
`define COND_V         4'hc

// ------------------------------------------------------------
// pipeline counts
// ------------------------------------------------------------
`define DELAY_SLOTS    2'h3
// one slot is already in the fetch register when the branch decodes
`define SLOTS_TO_FETCH 2'h2
`define ADDR_ONE       24'h000001
`define CNT_ZERO       32'h00000000
`define CNT_ONE        32'h00000001

// ------------------------------------------------------------
// single repeat states
// ------------------------------------------------------------
`define SGL_IDLE       2'h0
`define SGL_FETCH      2'h1
`define SGL_RUN        2'h2

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RESET_ADDR     24'h000000

`endif

// ---- core/condition_evaluator.v ----
// condition evaluator: decides a branch or call condition from flags.
// assumes the flags bus is the one captured when the previous
// instruction completed.
`timescale 1ns/1ps
`include "program_flow_sequencer_regs.vh"

module condition_evaluator (
   input  wire [`COND_W-1:0] condCode,   // condition field
   input  wire [`FLAG_W-1:0] flags,      // n z v c
   output reg                condTrue    // condition holds
);

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire c = flags[`FLAG_C];   // carry / borrow
   wire v = flags[`FLAG_V];   // overflow
   wire z = flags[`FLAG_Z];   // zero
   wire n = flags[`FLAG_N];   // negative

   // unknown codes read as never taken, the safe answer for a branch
   always @* begin
      case (condCode)
         `COND_U:  condTrue = 1'b1;
         `COND_LO: condTrue = c;
         `COND_LS: condTrue = c | z;
         `COND_HI: condTrue = ~c & ~z;
         `COND_HS: condTrue = ~c;
         `COND_EQ: condTrue = z;
         `COND_NE: condTrue = ~z;
         `COND_LT: condTrue = n;
         `COND_LE: condTrue = n | z;
         `COND_GT: condTrue = ~n & ~z;
         `COND_GE: condTrue = ~n;
         `COND_NV: condTrue = ~v;
         `COND_V:  condTrue = v;
         default:  condTrue = 1'b0;
      endcase
   end

endmodule // condition_evaluator

// ---- core/program_flow_sequencer.v ----
// program flow sequencer: fetch address, delayed branches, calls,
// block and single repeat loops.
// assumes decode sees each word one cycle after it is fetched and
// that software keeps the delay slots free of flow instructions.
//
// Function
// RULE1: delayed branch keeps pipeline, runs three slots
// RULE2: code keeps flow instructions out of slots
// RULE3: delayed condition uses flags before branch
// RULE4: block and single repeat, zero overhead
// RULE5: repeat loads start/end; software loads counter
// RULE6: counter N gives N plus one passes
// RULE7: loop end steers pc from loop registers
// RULE8: one loop register set, software saves it
// RULE9: single repeat uses same loop registers
// RULE10: single repeat fetches its instruction once
// RULE11: single repeat blocks interrupts, block doesn't
// RULE12: register call targets register value
// RULE13: at end: nonzero decrements and jumps, else falls
`timescale 1ns/1ps
`include "program_flow_sequencer_regs.vh"

module program_flow_sequencer (
   input  wire               clk,            // core clock
   input  wire               reset,          // sync, active high
   // fetch side
   input  wire               fetchStep,      // fetch took fetchAddr
   // decode side, one decoded word per valid cycle
   input  wire               instrValid,     // decoded word present
   input  wire [`ADDR_W-1:0] instrAddr,      // its address
   input  wire               isBranch,       // branch
   input  wire               isDelayed,      // delayed form of branch
   input  wire               isCall,         // call
   input  wire               isRegCall,      // call target from register
   input  wire               isReturn,       // subroutine or interrupt return
   input  wire               isBlockLoop,    // block_loop_instr
   input  wire               isSingleLoop,   // single_loop_instr
   input  wire [`COND_W-1:0] condCode,       // condition field
   input  wire [`FLAG_W-1:0] flags,          // flags after previous word
   input  wire [`ADDR_W-1:0] targetAddr,     // direct target or loop end
   input  wire [`ADDR_W-1:0] regValue,       // named register contents
   input  wire [`ADDR_W-1:0] returnAddr,     // popped return address
   // software access to the loop registers
   input  wire               startWrite,     // load start address
   input  wire               endWrite,       // load end address
   input  wire               counterWrite,   // load counter
   input  wire [`CNT_W-1:0]  writeData,      // value for the loads
   // outputs
   output reg  [`ADDR_W-1:0] fetchAddr_reg,     // next fetch address
   output reg                fetchEnable_reg,   // fetch may use bus
   output reg                flush_reg,         // drop fetched word
   output reg                repeatIssue_reg,   // reissue held word
   output reg                intInhibit_reg,    // interrupts held off
   output reg                pushReturn_reg,    // push return address
   output reg  [`ADDR_W-1:0] callReturn_reg,    // address to push
   output reg  [`ADDR_W-1:0] loopStartAddress_reg,     // loop_start_address
   output reg  [`ADDR_W-1:0] loopEndAddress_reg,       // loop_end_address
   output reg  [`CNT_W-1:0]  loopIterationCounter_reg, // loop_iteration_counter
   output reg                blockActive_reg,   // block loop armed
   output reg                branchPending_reg  // delayed branch in flight
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   reg [1:0]         slotCount_reg;    // slot fetches still to go
   reg [1:0]         slotCount_next;
   reg [`ADDR_W-1:0] branchTarget_reg; // target of delayed branch
   reg [`ADDR_W-1:0] branchTarget_next;
   reg [1:0]         sglState_reg;     // single repeat state
   reg [1:0]         sglState_next;
   reg [`ADDR_W-1:0] fetchAddr_next;
   reg               fetchEnable_next;
   reg               flush_next;
   reg               repeatIssue_next;
   reg               pushReturn_next;
   reg [`ADDR_W-1:0] callReturn_next;
   reg [`ADDR_W-1:0] loopStart_next;
   reg [`ADDR_W-1:0] loopEnd_next;
   reg [`CNT_W-1:0]  loopCount_next;
   reg               blockActive_next;
   reg               branchPending_next;
   reg               hwCount;          // hardware touches counter

   wire              condTrue;         // condition outcome

   // ------------------------------------------------------------
   // condition check
   // ------------------------------------------------------------
   // flags arrive as they stood when the previous word completed, so
   // slot instructions cannot change the decision
   condition_evaluator condCheck (
      .condCode (condCode),
      .flags    (flags),
      .condTrue (condTrue)        // [RULE3]
   );

   wire [`ADDR_W-1:0] seqAddr   = fetchAddr_reg + `ADDR_ONE;  // next word
   wire [`ADDR_W-1:0] afterInst = instrAddr + `ADDR_ONE;      // after decoded
   wire               atLoopEnd = blockActive_reg && fetchAddr_reg == loopEndAddress_reg;
   wire               counterNz = loopIterationCounter_reg != `CNT_ZERO;
   wire               takeFlow  = instrValid && condTrue;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always @* begin
      fetchAddr_next     = fetchAddr_reg;
      fetchEnable_next   = fetchEnable_reg;
      flush_next         = 1'b0;
      repeatIssue_next   = 1'b0;
      pushReturn_next    = 1'b0;
      callReturn_next    = callReturn_reg;
      loopStart_next     = loopStartAddress_reg;
      loopEnd_next       = loopEndAddress_reg;
      loopCount_next     = loopIterationCounter_reg;
      blockActive_next   = blockActive_reg;
      branchPending_next = branchPending_reg;
      branchTarget_next  = branchTarget_reg;
      slotCount_next     = slotCount_reg;
      sglState_next      = sglState_reg;
      hwCount            = 1'b0;

      // sequential fetch, with loop end and delay slot handling
      if (fetchStep && fetchEnable_reg) begin
         if (branchPending_reg && slotCount_reg == 2'h1) begin
            // last slot word leaves, target follows without a flush
            fetchAddr_next     = branchTarget_reg;          // [RULE1]
            branchPending_next = 1'b0;
            slotCount_next     = 2'h0;
         end else if (atLoopEnd && counterNz) begin
            // jump back in the same cycle: no overhead cycle
            fetchAddr_next = loopStartAddress_reg;          // [RULE7] [RULE13] [RULE4]
            loopCount_next = loopIterationCounter_reg - `CNT_ONE; // [RULE6]
            hwCount        = 1'b1;
         end else begin
            if (atLoopEnd) begin
               blockActive_next = 1'b0;                     // [RULE13]
            end
            fetchAddr_next = seqAddr;
            if (branchPending_reg) begin
               slotCount_next = slotCount_reg - 2'h1;
            end
         end
      end

      // decoded flow instructions override sequential fetch
      if (takeFlow && isBranch && isDelayed) begin
         // keep fetching the slot words, no flush
         branchPending_next = 1'b1;                         // [RULE1]
         branchTarget_next  = targetAddr;
         slotCount_next     = `SLOTS_TO_FETCH;
      end else if (takeFlow && (isBranch || isCall || isReturn)) begin
         flush_next         = 1'b1;
         branchPending_next = 1'b0;
         if (isReturn) begin
            fetchAddr_next = returnAddr;
         end else if (isCall && isRegCall) begin
            fetchAddr_next = regValue;                      // [RULE12]
         end else begin
            fetchAddr_next = targetAddr;
         end
         if (isCall) begin
            pushReturn_next = 1'b1;
            callReturn_next = afterInst;
         end
      end else if (instrValid && isBlockLoop) begin
         // start and end come from the code itself
         loopStart_next   = afterInst;                      // [RULE5]
         loopEnd_next     = targetAddr;                     // [RULE5]
         blockActive_next = 1'b1;                           // [RULE4]
      end else if (instrValid && isSingleLoop) begin
         // same registers, start and end on the one word
         loopStart_next   = afterInst;                      // [RULE9] [RULE5]
         loopEnd_next     = afterInst;                      // [RULE9]
         blockActive_next = 1'b0;                           // [RULE8]
         flush_next       = 1'b1;
         fetchAddr_next   = afterInst;
         fetchEnable_next = 1'b1;
         sglState_next    = `SGL_FETCH;
      end

      // single repeat sequencing
      case (sglState_reg)
         `SGL_IDLE: begin
         end
         `SGL_FETCH: begin
            // the word is fetched this once, then the bus is let go
            if (fetchStep) begin
               fetchEnable_next = 1'b0;                     // [RULE10]
               fetchAddr_next   = loopEndAddress_reg + `ADDR_ONE;
               sglState_next    = `SGL_RUN;
            end
         end
         `SGL_RUN: begin
            if (counterNz) begin
               // decode reissues the held word, one pass per cycle
               repeatIssue_next = 1'b1;                     // [RULE4] [RULE10]
               loopCount_next   = loopIterationCounter_reg - `CNT_ONE; // [RULE6]
               hwCount          = 1'b1;
            end else begin
               fetchEnable_next = 1'b1;
               sglState_next    = `SGL_IDLE;
            end
         end
         default: begin
            fetchEnable_next = 1'b1;
            sglState_next    = `SGL_IDLE;
         end
      endcase

      // software save and restore of the single register set; a
      // hardware decrement in the same cycle wins over a counter load
      if (startWrite) begin
         loopStart_next = writeData[`ADDR_W-1:0];           // [RULE8]
      end
      if (endWrite) begin
         loopEnd_next = writeData[`ADDR_W-1:0];             // [RULE8]
      end
      if (counterWrite && !hwCount) begin
         loopCount_next = writeData;                        // [RULE5]
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (reset) begin
         fetchAddr_reg            <= `RESET_ADDR;
         fetchEnable_reg          <= 1'b1;
         flush_reg                <= 1'b0;
         repeatIssue_reg          <= 1'b0;
         intInhibit_reg           <= 1'b0;
         pushReturn_reg           <= 1'b0;
         callReturn_reg           <= `RESET_ADDR;
         loopStartAddress_reg     <= `RESET_ADDR;
         loopEndAddress_reg       <= `RESET_ADDR;
         loopIterationCounter_reg <= `CNT_ZERO;
         blockActive_reg          <= 1'b0;
         branchPending_reg        <= 1'b0;
         branchTarget_reg         <= `RESET_ADDR;
         slotCount_reg            <= 2'h0;
         sglState_reg             <= `SGL_IDLE;
      end else begin
         fetchAddr_reg            <= fetchAddr_next;
         fetchEnable_reg          <= fetchEnable_next;
         flush_reg                <= flush_next;
         repeatIssue_reg          <= repeatIssue_next;
         // block loops stay interruptible; only single repeat holds off
         intInhibit_reg           <= sglState_next != `SGL_IDLE; // [RULE11]
         pushReturn_reg           <= pushReturn_next;
         callReturn_reg           <= callReturn_next;
         loopStartAddress_reg     <= loopStart_next;
         loopEndAddress_reg       <= loopEnd_next;
         loopIterationCounter_reg <= loopCount_next;
         blockActive_reg          <= blockActive_next;
         branchPending_reg        <= branchPending_next;
         branchTarget_reg         <= branchTarget_next;
         slotCount_reg            <= slotCount_next;
         sglState_reg             <= sglState_next;
      end
   end

endmodule // program_flow_sequencer

// ---- verif/program_flow_sequencer_chk.sv ----
// checker for the program flow sequencer: watches its ports only.
// assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "program_flow_sequencer_regs.vh"

module program_flow_sequencer_chk (
   input wire logic               clk,
   input wire logic               reset,
   input wire logic               instrValid,
   input wire logic [`ADDR_W-1:0] instrAddr,
   input wire logic               isBranch,
   input wire logic               isDelayed,
   input wire logic               isCall,
   input wire logic               isRegCall,
   input wire logic               isReturn,
   input wire logic               isBlockLoop,
   input wire logic               isSingleLoop,
   input wire logic [`COND_W-1:0] condCode,
   input wire logic [`ADDR_W-1:0] targetAddr,
   input wire logic [`ADDR_W-1:0] regValue,
   input wire logic               fetchStep,
   input wire logic [`ADDR_W-1:0] fetchAddr_reg,
   input wire logic               fetchEnable_reg,
   input wire logic               flush_reg,
   input wire logic               repeatIssue_reg,
   input wire logic               intInhibit_reg,
   input wire logic               pushReturn_reg,
   input wire logic [`ADDR_W-1:0] callReturn_reg,
   input wire logic [`ADDR_W-1:0] loopStartAddress_reg,
   input wire logic [`ADDR_W-1:0] loopEndAddress_reg,
   input wire logic [`CNT_W-1:0]  loopIterationCounter_reg,
   input wire logic               blockActive_reg,
   input wire logic               branchPending_reg
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // decode outside delay slots, so priority alone decides
   wire plain = instrValid && !branchPending_reg && condCode == `COND_U;
   wire flowHi = isBranch || isCall || isReturn;
   // fetch reaching the loop end with no decode redirect competing
   wire atEnd = blockActive_reg && fetchStep && fetchEnable_reg && !instrValid
                && !branchPending_reg && fetchAddr_reg == loopEndAddress_reg;
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_delay_keeps: assert property (plain && isBranch && isDelayed
      |=> branchPending_reg && !flush_reg) else $error("delayed branch flushed");
   a_pend_noflush: assert property (branchPending_reg |-> !flush_reg)
      else $error("flush during delay slots");
   a_reg_call: assert property (plain && isCall && isRegCall && !isBranch
      |=> flush_reg && pushReturn_reg && fetchAddr_reg == $past(regValue)
      && callReturn_reg == $past(instrAddr) + `ADDR_ONE) else $error("register call wrong");
   a_block_arm: assert property (plain && isBlockLoop && !flowHi
      |=> blockActive_reg && loopStartAddress_reg == $past(instrAddr) + `ADDR_ONE
      && loopEndAddress_reg == $past(targetAddr)) else $error("block loop not armed");
   a_single_arm: assert property (plain && isSingleLoop && !flowHi && !isBlockLoop
      |=> intInhibit_reg && loopStartAddress_reg == loopEndAddress_reg
      && loopStartAddress_reg == $past(instrAddr) + `ADDR_ONE) else $error("single not armed");
   a_reissue_nofetch: assert property (repeatIssue_reg
      |-> intInhibit_reg && !fetchEnable_reg) else $error("reissue with bus fetch");
   a_loop_wrap: assert property (atEnd && loopIterationCounter_reg != `CNT_ZERO
      |=> fetchAddr_reg == $past(loopStartAddress_reg)
      && loopIterationCounter_reg == $past(loopIterationCounter_reg) - `CNT_ONE)
      else $error("loop end no wrap");
   a_loop_exit: assert property (atEnd && loopIterationCounter_reg == `CNT_ZERO
      |=> fetchAddr_reg == $past(loopEndAddress_reg) + `ADDR_ONE && !blockActive_reg)
      else $error("loop end no exit");
   a_inhibit_end: assert property ($fell(intInhibit_reg)
      |-> fetchEnable_reg && !$past(fetchEnable_reg)) else $error("inhibit ended early");
endmodule // program_flow_sequencer_chk

bind program_flow_sequencer program_flow_sequencer_chk chk (
   .clk(clk), .reset(reset), .instrValid(instrValid), .instrAddr(instrAddr),
   .isBranch(isBranch), .isDelayed(isDelayed), .isCall(isCall), .isRegCall(isRegCall),
   .isReturn(isReturn), .isBlockLoop(isBlockLoop), .isSingleLoop(isSingleLoop),
   .condCode(condCode), .targetAddr(targetAddr), .regValue(regValue),
   .fetchStep(fetchStep), .fetchAddr_reg(fetchAddr_reg), .fetchEnable_reg(fetchEnable_reg),
   .flush_reg(flush_reg), .repeatIssue_reg(repeatIssue_reg),
   .intInhibit_reg(intInhibit_reg), .pushReturn_reg(pushReturn_reg),
   .callReturn_reg(callReturn_reg), .loopStartAddress_reg(loopStartAddress_reg),
   .loopEndAddress_reg(loopEndAddress_reg),
   .loopIterationCounter_reg(loopIterationCounter_reg),
   .blockActive_reg(blockActive_reg), .branchPending_reg(branchPending_reg));

// ---- verif/fetch_model.sv ----
// fetch stage model: steps the fetch address when allowed.
// assumes run and slow are driven at the rising clock edge.
`timescale 1ns/1ps

module fetch_model (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic run,       // fetch is active
   input  wire logic slow,      // step every other cycle
   output wire logic fetchStep  // fetch took the address
);
   logic phase_reg;  // alternates so a slow memory stalls the fetch
   // ------------------------------------------------------------
   // stall pattern
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (reset) begin
         phase_reg <= 1'b0;
      end else begin
         phase_reg <= ~phase_reg;
      end
   end
   assign fetchStep = run && (!slow || phase_reg);
endmodule // fetch_model

// ---- verif/tb_program_flow_sequencer.sv ----
// testbench for the program flow sequencer: decode driven by hand.
// assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "program_flow_sequencer_regs.vh"

module tb_program_flow_sequencer;
   logic clk = 0, reset = 1, run = 0, slow = 0, instrValid = 0;
   logic isBranch = 0, isDelayed = 0, isCall = 0, isRegCall = 0, isReturn = 0;
   logic isBlockLoop = 0, isSingleLoop = 0;
   logic startWrite = 0, endWrite = 0, counterWrite = 0;
   logic [23:0] instrAddr = 0, targetAddr = 0, regValue = 24'h001234;
   logic [23:0] returnAddr = 24'h000abc;
   logic [3:0]  condCode = 0, flags = 0;
   logic [31:0] writeData = 0;
   wire         fetchStep, fetchEnable_reg, flush_reg, repeatIssue_reg, intInhibit_reg;
   wire         pushReturn_reg, blockActive_reg, branchPending_reg;
   wire [23:0]  fetchAddr_reg, callReturn_reg, loopStartAddress_reg, loopEndAddress_reg;
   wire [31:0]  loopIterationCounter_reg;
   integer      fail_count = 0, compares = 0, cyc = 0;

   always #25 clk = ~clk;  // 20 MHz
   fetch_model fm (.clk(clk), .reset(reset), .run(run), .slow(slow), .fetchStep(fetchStep));
   program_flow_sequencer uut (.clk(clk), .reset(reset), .fetchStep(fetchStep),
      .instrValid(instrValid), .instrAddr(instrAddr), .isBranch(isBranch),
      .isDelayed(isDelayed), .isCall(isCall), .isRegCall(isRegCall), .isReturn(isReturn),
      .isBlockLoop(isBlockLoop), .isSingleLoop(isSingleLoop), .condCode(condCode),
      .flags(flags), .targetAddr(targetAddr), .regValue(regValue), .returnAddr(returnAddr),
      .startWrite(startWrite), .endWrite(endWrite), .counterWrite(counterWrite),
      .writeData(writeData), .fetchAddr_reg(fetchAddr_reg), .fetchEnable_reg(fetchEnable_reg),
      .flush_reg(flush_reg), .repeatIssue_reg(repeatIssue_reg),
      .intInhibit_reg(intInhibit_reg), .pushReturn_reg(pushReturn_reg),
      .callReturn_reg(callReturn_reg), .loopStartAddress_reg(loopStartAddress_reg),
      .loopEndAddress_reg(loopEndAddress_reg),
      .loopIterationCounter_reg(loopIterationCounter_reg),
      .blockActive_reg(blockActive_reg), .branchPending_reg(branchPending_reg));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         $display("Error %s expected %h seen %h", n, e, s);
         fail_count++;
      end
   endtask
   task test_done;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // one decoded word; flags flip afterwards as the slots would do
   task issue(input [6:0] k, input [23:0] a, input [23:0] t, input [3:0] c, input [3:0] f);
      @(posedge clk);
      {isBranch, isDelayed, isCall, isRegCall, isReturn, isBlockLoop, isSingleLoop} <= k;
      instrValid <= 1; instrAddr <= a; targetAddr <= t; condCode <= c; flags <= f;
      @(posedge clk);
      {isBranch, isDelayed, isCall, isRegCall, isReturn, isBlockLoop, isSingleLoop} <= 0;
      instrValid <= 0; flags <= ~f;
      #1;
   endtask
   // software load of the loop registers
   task wr(input [2:0] w, input [31:0] d);
      @(posedge clk);
      {startWrite, endWrite, counterWrite} <= w; writeData <= d;
      @(posedge clk);
      {startWrite, endWrite, counterWrite} <= 0;
      #1;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_reset;
      chk("fetchAddr", fetchAddr_reg, 0);
      chk("fetchEnable", fetchEnable_reg, 1);
      chk("counter", loopIterationCounter_reg, 0);
      chk("blockActive", blockActive_reg, 0);
      $display("test reset done");
   endtask
   task t_delay(input [3:0] c, input [3:0] f, input tk);
      logic [23:0] a;
      a = fetchAddr_reg;
      issue(7'b1100000, 24'h60, 24'h90, c, f);
      chk("branchPending", branchPending_reg, tk);
      chk("flush", flush_reg, 0);
      @(posedge clk) run <= 1;
      @(posedge clk);
      @(posedge clk) run <= 0;
      #1;
      chk("fetchAddr", fetchAddr_reg, tk ? 24'h90 : a + 24'h2);
      chk("branchPending", branchPending_reg, 0);
      $display("test delayed branch done");
   endtask
   task t_call(input [6:0] k, input [3:0] c, input [3:0] f, input tk, input [23:0] e);
      logic [23:0] a;
      a = fetchAddr_reg;
      issue(k, 24'h50, 24'h0, c, f);
      chk("flush", flush_reg, tk);
      chk("fetchAddr", fetchAddr_reg, tk ? e : a);
      chk("pushReturn", pushReturn_reg, tk && k[4]);
      if (tk && k[4]) chk("callReturn", callReturn_reg, 24'h51);
      $display("test call done");
   endtask
   task t_block;
      integer i, p;
      wr(3'b001, 32'h2);
      issue(7'b1000000, 24'h1e, 24'h20, `COND_U, 0);
      issue(7'b0000010, 24'h1f, 24'h22, `COND_U, 0);
      chk("start", loopStartAddress_reg, 24'h20);
      chk("end", loopEndAddress_reg, 24'h22);
      @(posedge clk) begin run <= 1; slow <= 1; end
      p = 0;
      for (i = 0; i < 60 && blockActive_reg === 1'b1; i++) begin
         @(negedge clk);
         if (fetchStep && fetchEnable_reg && fetchAddr_reg === 24'h22) p++;
      end
      @(posedge clk) begin run <= 0; slow <= 0; end
      #1;
      chk("passes", p, 3);
      chk("fetchAddr", fetchAddr_reg, 24'h23);
      chk("counter", loopIterationCounter_reg, 0);
      $display("test block loop done");
   endtask
   task t_single;
      integer i, r, bad;
      wr(3'b001, 32'h3);
      issue(7'b0000001, 24'h40, 24'h0, `COND_U, 0);
      chk("start", loopStartAddress_reg, 24'h41);
      chk("end", loopEndAddress_reg, 24'h41);
      chk("intInhibit", intInhibit_reg, 1);
      @(posedge clk) run <= 1;
      r = 0;
      bad = 0;
      for (i = 0; i < 20 && intInhibit_reg === 1'b1; i++) begin
         @(negedge clk);
         if (repeatIssue_reg === 1'b1) r++;
         if (repeatIssue_reg === 1'b1 && fetchEnable_reg !== 1'b0) bad++;
      end
      @(posedge clk) run <= 0;
      #1;
      chk("reissues", r, 3);
      chk("busFetches", bad, 0);
      chk("intInhibit", intInhibit_reg, 0);
      chk("fetchEnable", fetchEnable_reg, 1);
      $display("test single loop done");
   endtask
   task t_regset;
      wr(3'b100, 32'h77);
      wr(3'b010, 32'h88);
      chk("start", loopStartAddress_reg, 24'h77);
      chk("end", loopEndAddress_reg, 24'h88);
      $display("test loop registers done");
   endtask

   // ------------------------------------------------------------
   // main sequence and hang guard
   // ------------------------------------------------------------
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         test_done;
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      reset <= 0;
      @(posedge clk);
      #1;
      t_reset;
      t_delay(`COND_U, 4'h0, 1);
      t_delay(`COND_EQ, 4'h4, 1);
      t_delay(`COND_EQ, 4'h0, 0);
      t_call(7'b0011000, `COND_U, 4'h0, 1, 24'h1234);
      t_call(7'b0011000, `COND_NE, 4'h4, 0, 24'h1234);
      t_call(7'b0000100, `COND_U, 4'h0, 1, 24'h0abc);
      t_block;
      t_single;
      t_regset;
      test_done;
   end
endmodule // tb_program_flow_sequencer
